// ==== verilog/fieldbus_diag_pkg.sv ====
// Package with register map, field layouts, codes and carrier structs of the state/diag block
package fieldbus_diag_pkg;
  // --------
  // Register map
  // --------
  localparam int ADDR_W = 16;
  localparam logic [ADDR_W-1:0] IDX_STATE_REQUEST = 16'h2000;
  localparam logic [ADDR_W-1:0] IDX_STATE_SUMMARY = 16'h2001;
  localparam logic [ADDR_W-1:0] ADDR_STATE_REQUEST = 16'(IDX_STATE_REQUEST * 4);
  localparam logic [ADDR_W-1:0] ADDR_STATE_SUMMARY = 16'(IDX_STATE_SUMMARY * 4);
  localparam logic [ADDR_W-1:0] ADDR_HISTORY_FLAGS = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_DIAG_STATUS = 16'h0004;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 16'h0008;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 16'h000C;
  localparam logic [ADDR_W-1:0] ADDR_MSG_BASE = 16'h0400;
  // --------
  // Master state codes
  // --------
  localparam logic [3:0] MS_INVALID = 4'h0;
  localparam logic [3:0] MS_INIT = 4'h1;
  localparam logic [3:0] MS_PREOP = 4'h2;
  localparam logic [3:0] MS_BOOT = 4'h3;
  localparam logic [3:0] MS_SAFEOP = 4'h4;
  localparam logic [3:0] MS_OP = 4'h8;
  localparam logic [31:0] STATE_REQUEST_RESET = 32'h0000_0001;
  // --------
  // Summary word bit positions
  // --------
  localparam int SUM_MASTER_OK = 0;
  localparam int SUM_STATE_LSB = 4;
  localparam int SUM_SLAVES_IN_REQ = 8;
  localparam int SUM_MASTER_IN_REQ = 9;
  localparam int SUM_SCAN_MATCH = 10;
  localparam int SUM_CLOCK_ENABLED = 12;
  localparam int SUM_CLOCK_LOCKED = 13;
  localparam int SUM_CLOCK_BUSY = 14;
  localparam int SUM_LINK_UP = 16;
  // --------
  // History flags, interrupt bits
  // --------
  localparam int HF_EMERGENCY = 0;
  localparam int HF_NO_INFO = 1;
  localparam int HF_NO_WARNING = 2;
  localparam int HF_NO_ERROR = 3;
  localparam logic [3:0] HISTORY_FLAGS_RESET = 4'h0;
  localparam int IRQ_STATE_REACHED = 0;
  localparam int IRQ_MSG_STORED = 1;
  localparam int IRQ_MSG_REJECTED = 2;
  localparam int IRQ_MSG_SUPPRESSED = 3;
  localparam int IRQ_W = 4;
  // --------
  // Stored message layout (byte offsets and field codes)
  // --------
  localparam int MSG_BYTE_CODE = 0;
  localparam int MSG_BYTE_FLAGS = 4;
  localparam int MSG_BYTE_TEXT = 6;
  localparam int MSG_BYTE_TIME = 8;
  localparam int MSG_BYTE_PFLAGS = 16;
  localparam int MSG_BYTE_PDATA = 18;
  localparam int MSG_WORDS = 8;
  localparam logic [3:0] CODE_CLASS_EMERGENCY = 4'hE;
  localparam logic [15:0] CODE_HIGH_RESERVED_LO = 16'h0000;
  localparam logic [15:0] CODE_HIGH_RESERVED_HI = 16'hFFFF;
  localparam logic [3:0] SEV_INFO = 4'h0;
  localparam logic [3:0] SEV_WARNING = 4'h1;
  localparam logic [3:0] SEV_ERROR = 4'h2;
  localparam logic [3:0] PK_TYPED = 4'h0;
  localparam logic [3:0] PK_BYTES = 4'h1;
  localparam logic [3:0] PK_ASCII = 4'h2;
  localparam logic [3:0] PK_WIDE = 4'h3;
  localparam logic [3:0] PK_TEXTREF = 4'h4;
  // --------
  // Carriers
  // --------
  typedef struct packed {
    logic [3:0] currentState;
    logic slavesInReqState;
    logic busScanMatch;
    logic clockSyncEnabled;
    logic clockSyncLocked;
    logic clockSyncBusy;
  } master_status_s;
  typedef struct packed {
    logic [31:0] code;
    logic [3:0] severity;
    logic [15:0] textReference;
    logic [15:0] paramFlags;
    logic [79:0] paramData;
  } diag_msg_s;
endpackage

// ==== verilog/diag_msg_ram.sv ====
// Simple dual-port message memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module diag_msg_ram #(
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  // Clock
  input wire logic clock,
  // Write port
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [31:0] wrData,
  // Read port
  input wire logic rdEn,
  input wire logic [AW-1:0] rdAddr,
  output logic [31:0] rdData
);
  logic [31:0] mem [DEPTH];

  always_ff @(posedge clock)
  begin
    if (wrEn)
    begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rdEn)
    begin
      rdData <= mem[rdAddr];
    end
  end
endmodule
`default_nettype wire

// ==== verilog/fieldbus_master_state_diag.sv ====
// Master state request/summary registers and diagnosis message store behind AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Request register holds legal master state codes
// - Summary bit0 is master healthy; reserved zero
// - Summary bits 4-7 show current master state
// - Bits 8,9,10: slaves, master, scan match
// - Bits 12-14 clock sync, bit16 link up
// - Master OK needs topology, operational, sync locked if enabled
// - Message starts with code; reserved codes refused
// - Flags at byte 4 carry severity 0-2
// - Text reference at byte 6, zero none
// - Timestamp at byte 8, parameters from 16
// - Parameter kind in flag bits 12-15 checked
// - History flags suppress storing; bit0 emergency
module fieldbus_master_state_diag
  import fieldbus_diag_pkg::*;
#(
  parameter int MSG_SLOTS = 8,
  parameter int SLOT_W = 3
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // AXI4-Lite write address and data
  input wire logic [fieldbus_diag_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [fieldbus_diag_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Master engine side
  input wire fieldbus_diag_pkg::master_status_s masterStatus,
  input wire logic linkUpPin,
  output logic [3:0] requestedState,
  // Diagnosis message input
  input wire fieldbus_diag_pkg::diag_msg_s diagMsg,
  input wire logic diagMsgValid,
  output logic diagMsgReady,
  input wire logic [63:0] clockSyncTimeNs,
  // Outputs to system
  output logic emergencyPulse,
  output logic irq
);
  localparam int MEM_AW = SLOT_W + 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {RD_IDLE, RD_MEM, RD_RESP} rd_state_e;
  typedef enum logic {ST_IDLE, ST_WRITE} store_state_e;

  // --------
  // Helpers
  // --------
  function automatic logic isStateCode(input logic [31:0] v);
    return v == {28'h0, MS_INVALID} || v == {28'h0, MS_INIT} || v == {28'h0, MS_PREOP}
      || v == {28'h0, MS_BOOT} || v == {28'h0, MS_SAFEOP} || v == {28'h0, MS_OP};
  endfunction

  function automatic logic isMsgAddr(input logic [ADDR_W-1:0] a);
    return a >= ADDR_MSG_BASE && a < ADDR_MSG_BASE + 16'(MSG_SLOTS * MSG_WORDS * 4);
  endfunction

  // Byte-enable merge: enabled bytes take the write data, the others keep the old value
  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] d,
                                             input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (s[i])
      begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  // --------
  // Link-up pin synchroniser
  // --------
  logic linkMeta_r;
  logic linkUp_r;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      linkMeta_r <= 1'b0;
      linkUp_r <= 1'b0;
    end
    else
    begin
      linkMeta_r <= linkUpPin;
      linkUp_r <= linkMeta_r;
    end
  end

  // --------
  // AXI write channel
  // --------
  logic awHeld_r;
  logic wHeld_r;
  logic [ADDR_W-1:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic doWrite;
  logic [31:0] stateRequest_r;
  logic [3:0] historyFlags_r;
  logic [IRQ_W-1:0] irqMask_r;
  logic [31:0] reqMerged;
  logic wrOk;

  assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_r && !s_axi_bvalid;
  assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
  assign reqMerged = mergeBytes(stateRequest_r, wData_r, wStrb_r);

  always_comb
  begin
    unique case (awAddr_r)
      ADDR_STATE_REQUEST: wrOk = isStateCode(reqMerged);
      ADDR_HISTORY_FLAGS: wrOk = 1'b1;
      ADDR_IRQ_MASK: wrOk = 1'b1;
      default: wrOk = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= '0;
      wData_r <= '0;
      wStrb_r <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrOk ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // --------
  // Software-written registers
  // --------
  // Illegal state codes are refused so the engine only ever sees a valid target
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stateRequest_r <= STATE_REQUEST_RESET;
      historyFlags_r <= HISTORY_FLAGS_RESET;
      irqMask_r <= '0;
    end
    else if (doWrite && wrOk)
    begin
      if (awAddr_r == ADDR_STATE_REQUEST)
      begin
        stateRequest_r <= reqMerged;
      end
      if (awAddr_r == ADDR_HISTORY_FLAGS && wStrb_r[0])
      begin
        historyFlags_r <= wData_r[3:0];
      end
      if (awAddr_r == ADDR_IRQ_MASK && wStrb_r[0])
      begin
        irqMask_r <= wData_r[IRQ_W-1:0];
      end
    end
  end

  assign requestedState = stateRequest_r[3:0];

  // --------
  // State summary
  // --------
  logic masterInReq;
  logic masterOk;
  logic reqPending_r;
  logic [31:0] summary;

  // Compared live, so a new request drops the flag in the same cycle it lands
  assign masterInReq = masterStatus.currentState == requestedState;
  assign masterOk = masterStatus.busScanMatch && masterStatus.currentState == MS_OP
    && masterStatus.slavesInReqState && requestedState == MS_OP
    && (!masterStatus.clockSyncEnabled || masterStatus.clockSyncLocked);

  always_comb
  begin
    summary = '0;
    summary[SUM_MASTER_OK] = masterOk;
    summary[SUM_STATE_LSB +: 4] = masterStatus.currentState;
    summary[SUM_SLAVES_IN_REQ] = masterStatus.slavesInReqState;
    summary[SUM_MASTER_IN_REQ] = masterInReq;
    summary[SUM_SCAN_MATCH] = masterStatus.busScanMatch;
    summary[SUM_CLOCK_ENABLED] = masterStatus.clockSyncEnabled;
    summary[SUM_CLOCK_LOCKED] = masterStatus.clockSyncLocked;
    summary[SUM_CLOCK_BUSY] = masterStatus.clockSyncBusy;
    summary[SUM_LINK_UP] = linkUp_r;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reqPending_r <= 1'b0;
    end
    else if (doWrite && wrOk && awAddr_r == ADDR_STATE_REQUEST)
    begin
      reqPending_r <= 1'b1;
    end
    else if (reqPending_r && masterInReq)
    begin
      reqPending_r <= 1'b0;
    end
  end

  // --------
  // Diagnosis message store
  // --------
  store_state_e storeState_r;
  diag_msg_s msg_r;
  logic [63:0] stamp_r;
  logic [2:0] wordIdx_r;
  logic [SLOT_W-1:0] newestSlot_r;
  logic [SLOT_W:0] msgCount_r;
  logic msgLegal;
  logic msgMuted;
  logic [31:0] memWrData;
  logic msgTaken;

  assign diagMsgReady = storeState_r == ST_IDLE;
  assign msgTaken = diagMsgValid && diagMsgReady;

  always_comb
  begin
    msgLegal = diagMsg.code[31:16] != CODE_HIGH_RESERVED_LO
      && diagMsg.code[31:16] != CODE_HIGH_RESERVED_HI;
    msgLegal = msgLegal && diagMsg.severity <= SEV_ERROR;
    unique case (diagMsg.paramFlags[15:12])
      PK_TYPED, PK_BYTES, PK_ASCII, PK_WIDE: msgLegal = msgLegal;
      PK_TEXTREF: msgLegal = msgLegal && diagMsg.paramFlags[11:0] == 12'h000;
      default: msgLegal = 1'b0;
    endcase
    unique case (diagMsg.severity)
      SEV_INFO: msgMuted = historyFlags_r[HF_NO_INFO];
      SEV_WARNING: msgMuted = historyFlags_r[HF_NO_WARNING];
      default: msgMuted = historyFlags_r[HF_NO_ERROR];
    endcase
  end

  // Word layout: code | flags,text | time lo | time hi | pflags,data | data...
  always_comb
  begin
    unique case (wordIdx_r)
      3'(MSG_BYTE_CODE / 4): memWrData = msg_r.code;
      3'(MSG_BYTE_FLAGS / 4): memWrData = {msg_r.textReference, 12'h000, msg_r.severity};
      3'(MSG_BYTE_TIME / 4): memWrData = stamp_r[31:0];
      3'(MSG_BYTE_TIME / 4 + 1): memWrData = stamp_r[63:32];
      3'(MSG_BYTE_PFLAGS / 4): memWrData = {msg_r.paramData[15:0], msg_r.paramFlags};
      3'(MSG_BYTE_PDATA / 4 + 1): memWrData = msg_r.paramData[47:16];
      3'(MSG_BYTE_PDATA / 4 + 2): memWrData = msg_r.paramData[79:48];
      default: memWrData = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      storeState_r <= ST_IDLE;
      msg_r <= '0;
      stamp_r <= '0;
      wordIdx_r <= '0;
      newestSlot_r <= '1;
      msgCount_r <= '0;
    end
    else
    begin
      unique case (storeState_r)
        ST_IDLE:
        begin
          if (msgTaken && msgLegal && !msgMuted)
          begin
            msg_r <= diagMsg;
            stamp_r <= clockSyncTimeNs;
            wordIdx_r <= '0;
            newestSlot_r <= newestSlot_r + 1'b1;
            storeState_r <= ST_WRITE;
          end
        end
        ST_WRITE:
        begin
          wordIdx_r <= wordIdx_r + 1'b1;
          if (wordIdx_r == 3'(MSG_WORDS - 1))
          begin
            storeState_r <= ST_IDLE;
            if (msgCount_r != (SLOT_W + 1)'(MSG_SLOTS))
            begin
              msgCount_r <= msgCount_r + 1'b1;
            end
          end
        end
      endcase
    end
  end

  // Emergency copy goes out only for emergency-class codes when enabled
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      emergencyPulse <= 1'b0;
    end
    else
    begin
      emergencyPulse <= msgTaken && msgLegal && !msgMuted && historyFlags_r[HF_EMERGENCY]
        && diagMsg.code[15:12] == CODE_CLASS_EMERGENCY;
    end
  end

  // --------
  // AXI read channel
  // --------
  rd_state_e rdState_r;
  logic [ADDR_W-1:0] arAddr_r;
  logic [31:0] memRdData;
  logic [31:0] regRdData;
  logic regRdOk;
  logic arTake;
  logic irqRead;

  assign s_axi_arready = rdState_r == RD_IDLE;
  assign arTake = s_axi_arvalid && s_axi_arready;
  assign irqRead = arTake && s_axi_araddr == ADDR_IRQ_STATUS;

  logic [IRQ_W-1:0] irqStatus_r;

  always_comb
  begin
    regRdOk = 1'b1;
    unique case (s_axi_araddr)
      ADDR_STATE_REQUEST: regRdData = stateRequest_r;
      ADDR_STATE_SUMMARY: regRdData = summary;
      ADDR_HISTORY_FLAGS: regRdData = {28'h0, historyFlags_r};
      ADDR_DIAG_STATUS: regRdData = {16'h0, 8'(msgCount_r), 8'(newestSlot_r)};
      ADDR_IRQ_STATUS: regRdData = {28'h0, irqStatus_r};
      ADDR_IRQ_MASK: regRdData = {28'h0, irqMask_r};
      default:
      begin
        regRdData = 32'h0000_0000;
        regRdOk = 1'b0;
      end
    endcase
  end

  diag_msg_ram #(
    .DEPTH(MSG_SLOTS * MSG_WORDS),
    .AW(MEM_AW)
  ) u_ram (
    .clock(clock),
    .wrEn(storeState_r == ST_WRITE),
    .wrAddr({newestSlot_r, wordIdx_r}),
    .wrData(memWrData),
    .rdEn(arTake),
    .rdAddr(s_axi_araddr[MEM_AW+1:2]),
    .rdData(memRdData)
  );

  // Message window reads cost one extra cycle for the registered memory
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdState_r <= RD_IDLE;
      arAddr_r <= '0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      unique case (rdState_r)
        RD_IDLE:
        begin
          if (arTake)
          begin
            arAddr_r <= s_axi_araddr;
            if (isMsgAddr(s_axi_araddr))
            begin
              rdState_r <= RD_MEM;
            end
            else
            begin
              s_axi_rdata <= regRdData;
              s_axi_rresp <= regRdOk ? RESP_OKAY : RESP_SLVERR;
              s_axi_rvalid <= 1'b1;
              rdState_r <= RD_RESP;
            end
          end
        end
        RD_MEM:
        begin
          s_axi_rdata <= memRdData;
          s_axi_rresp <= RESP_OKAY;
          s_axi_rvalid <= 1'b1;
          rdState_r <= RD_RESP;
        end
        RD_RESP:
        begin
          if (s_axi_rready)
          begin
            s_axi_rvalid <= 1'b0;
            rdState_r <= RD_IDLE;
          end
        end
        default: rdState_r <= RD_IDLE;
      endcase
    end
  end

  // --------
  // Interrupts: sticky events, cleared by reading, set wins
  // --------
  logic [IRQ_W-1:0] irqEvents;

  always_comb
  begin
    irqEvents = '0;
    irqEvents[IRQ_STATE_REACHED] = reqPending_r && masterInReq;
    irqEvents[IRQ_MSG_STORED] = msgTaken && msgLegal && !msgMuted;
    irqEvents[IRQ_MSG_REJECTED] = msgTaken && !msgLegal;
    irqEvents[IRQ_MSG_SUPPRESSED] = msgTaken && msgLegal && msgMuted;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irqStatus_r <= '0;
    end
    else
    begin
      irqStatus_r <= (irqRead ? '0 : irqStatus_r) | irqEvents;
    end
  end

  assign irq = |(irqStatus_r & irqMask_r);
endmodule
`default_nettype wire

// ==== sim/fieldbus_diag_assertions.sv ====
// Port-level checks for the master state and diagnosis block
`timescale 1ns/1ps
`default_nettype none
module fieldbus_diag_assertions
  import fieldbus_diag_pkg::*;
(
  // Clock, reset, bus
  input wire logic clock,
  input wire logic reset_n,
  input wire logic s_axi_bvalid,
  input wire logic [fieldbus_diag_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  // Engine and messages
  input wire fieldbus_diag_pkg::master_status_s masterStatus,
  input wire logic [3:0] requestedState,
  input wire fieldbus_diag_pkg::diag_msg_s diagMsg,
  input wire logic diagMsgValid,
  input wire logic diagMsgReady,
  input wire logic emergencyPulse
);
  logic okNow;
  logic [6:0] flagsNow;
  assign okNow = masterStatus.busScanMatch && masterStatus.slavesInReqState
    && masterStatus.currentState == MS_OP && requestedState == MS_OP
    && (!masterStatus.clockSyncEnabled || masterStatus.clockSyncLocked);
  assign flagsNow = {masterStatus.clockSyncBusy, masterStatus.clockSyncLocked,
    masterStatus.clockSyncEnabled, 1'b0, masterStatus.busScanMatch,
    masterStatus.currentState == requestedState, masterStatus.slavesInReqState};
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  sequence sumRead;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_STATE_SUMMARY;
  endsequence
  sequence msgTaken;
    diagMsgValid && diagMsgReady;
  endsequence
  req_legal_a: assert property (requestedState inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8})
    else $error("illegal requested state");
  req_hold_a: assert property ($changed(requestedState) |-> $rose(s_axi_bvalid))
    else $error("request moved without a write");
  sum_reserved_a: assert property (sumRead |=> (s_axi_rdata & 32'hFFFE_880E) == 32'h0)
    else $error("summary reserved bit set");
  sum_state_a: assert property (sumRead |=>
    s_axi_rdata[7:4] == $past(masterStatus.currentState)) else $error("summary state wrong");
  sum_flags_a: assert property (sumRead |=> s_axi_rdata[14:8] == $past(flagsNow))
    else $error("summary flags wrong");
  sum_ok_a: assert property (sumRead |=> s_axi_rdata[0] == $past(okNow))
    else $error("master ok wrong");
  bad_code_a: assert property (msgTaken ##0
    (diagMsg.code[31:16] inside {16'h0000, 16'hFFFF}) |=> diagMsgReady)
    else $error("reserved code stored");
  bad_sev_a: assert property (msgTaken ##0 (diagMsg.severity > 4'h2) |=> diagMsgReady)
    else $error("bad severity stored");
  bad_kind_a: assert property (msgTaken ##0 (diagMsg.paramFlags[15:12] > 4'h4 ||
    diagMsg.paramFlags[15:12] == 4'h4 && diagMsg.paramFlags[11:0] != 12'h0) |=> diagMsgReady)
    else $error("bad parameter kind stored");
  emerg_pulse_a: assert property (emergencyPulse |=> !emergencyPulse)
    else $error("emergency pulse too long");
endmodule
`default_nettype wire

// ==== sim/master_engine_model.sv ====
// Behavioural master engine that walks toward the requested state
`timescale 1ns/1ps
`default_nettype none
module master_engine_model
  import fieldbus_diag_pkg::*;
#(
  parameter int LAG = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Request in, status out
  input wire logic [3:0] requestedState,
  input wire logic scanOk,
  input wire logic [2:0] clockFlags,
  output var fieldbus_diag_pkg::master_status_s masterStatus
);
  logic [3:0] state_r;
  logic [3:0] wait_r;
  // Transitions take several cycles, so the in-state flag is seen low first
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= MS_INIT;
      wait_r <= 4'h0;
    end
    else if (state_r == requestedState)
      wait_r <= 4'h0;
    else if (wait_r == 4'(LAG))
      state_r <= requestedState;
    else
      wait_r <= wait_r + 4'h1;
  end
  assign masterStatus = {state_r, state_r == requestedState, scanOk, clockFlags};
endmodule
`default_nettype wire

// ==== sim/fieldbus_master_state_diag_test.sv ====
// Self-checking bench for the master state and diagnosis block
`timescale 1ns/1ps
`default_nettype none
module fieldbus_master_state_diag_test;
  import fieldbus_diag_pkg::*;
  logic clock, reset_n, av, wv, br, arv, rr, mv, lk, so;
  logic awr, wr, bv, arr, rv, mr, ep, irq;
  logic [15:0] aa, ra;
  logic [31:0] wd, rd, d;
  logic [1:0] bres, rres, r;
  logic [2:0] cf;
  logic [3:0] rq;
  logic [63:0] ts;
  diag_msg_s msg;
  master_status_s ms;
  int failCount, nTests, epCount;
  fieldbus_master_state_diag uut (.clock(clock), .reset_n(reset_n), .s_axi_awaddr(aa),
    .s_axi_awvalid(av), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bres), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ra), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rres), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .masterStatus(ms), .linkUpPin(lk), .requestedState(rq), .diagMsg(msg),
    .diagMsgValid(mv), .diagMsgReady(mr), .clockSyncTimeNs(ts), .emergencyPulse(ep), .irq(irq));
  master_engine_model eng (.clock(clock), .reset_n(reset_n), .requestedState(rq),
    .scanOk(so), .clockFlags(cf), .masterStatus(ms));
  always @(negedge clock)
    if (ep === 1'b1)
      epCount++;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      failCount++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Handshakes are judged at the negedge, where every signal has settled
  task automatic wchk(input logic [15:0] a, input logic [31:0] v, input logic [1:0] e);
    logic ta, tw, done;
    aa <= a;
    wd <= v;
    av <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    done = 1'b0;
    while (!done)
    begin
      @(negedge clock);
      ta = av && awr;
      tw = wv && wr;
      done = bv;
      r = bres;
      @(posedge clock);
      if (ta)
        av <= 1'b0;
      if (tw)
        wv <= 1'b0;
    end
    check({30'h0, r}, {30'h0, e});
  endtask
  task automatic rdw(input logic [15:0] a);
    logic tk, done;
    ra <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    done = 1'b0;
    while (!done)
    begin
      @(negedge clock);
      tk = arv && arr;
      done = rv;
      d = rd;
      r = rres;
      @(posedge clock);
      if (tk)
        arv <= 1'b0;
    end
  endtask
  task automatic rchk(input logic [15:0] a, input logic [31:0] e);
    rdw(a);
    check(d, e);
  endtask
  task automatic send(input logic [31:0] c, input logic [3:0] s, input logic [15:0] f);
    logic done;
    msg <= {c, s, 16'hA5C3, f, 80'h0123_4567_89AB_CDEF_1357};
    mv <= 1'b1;
    done = 1'b0;
    while (!done)
    begin
      @(negedge clock);
      done = mr;
      @(posedge clock);
    end
    mv <= 1'b0;
    repeat (10) @(posedge clock);
  endtask
  task automatic bad(input logic [31:0] c, input logic [3:0] s, input logic [15:0] f);
    send(c, s, f);
    rchk(ADDR_IRQ_STATUS, 32'h4);
  endtask
  function automatic logic [15:0] slot(input int s, input int w);
    return ADDR_MSG_BASE + 16'(s * 32 + w * 4);
  endfunction
  // ----------------
  // Scenarios
  // ----------------
  task automatic t_regs();
    rchk(ADDR_STATE_REQUEST, STATE_REQUEST_RESET);
    rchk(ADDR_HISTORY_FLAGS, 32'h0);
    rchk(ADDR_IRQ_MASK, 32'h0);
    rchk(ADDR_DIAG_STATUS, 32'h7);
    rdw(16'h0100);
    check({30'h0, r}, 32'h2);
  endtask
  task automatic t_states();
    logic [3:0] codes [6];
    codes = '{MS_PREOP, MS_BOOT, MS_SAFEOP, MS_OP, MS_INVALID, MS_INIT};
    foreach (codes[i])
    begin
      wchk(ADDR_STATE_REQUEST, {28'h0, codes[i]}, 2'b00);
      rchk(ADDR_STATE_REQUEST, {28'h0, codes[i]});
      rdw(ADDR_STATE_SUMMARY);
      check({31'h0, d[9]}, 32'h0);
      repeat (8) @(posedge clock);
      rdw(ADDR_STATE_SUMMARY);
      check({d[9], d[7:4]}, {1'b1, codes[i]});
    end
    wchk(ADDR_STATE_REQUEST, 32'h5, 2'b10);
    rchk(ADDR_STATE_REQUEST, 32'h1);
  endtask
  task automatic t_summary();
    wchk(ADDR_STATE_REQUEST, 32'h8, 2'b00);
    so <= 1'b1;
    cf <= 3'b110;
    lk <= 1'b1;
    repeat (8) @(posedge clock);
    rchk(ADDR_STATE_SUMMARY, 32'h0001_3781);
    cf <= 3'b101;
    rchk(ADDR_STATE_SUMMARY, 32'h0001_5780);
    so <= 1'b0;
    cf <= 3'b000;
    lk <= 1'b0;
    repeat (3) @(posedge clock);
    rchk(ADDR_STATE_SUMMARY, 32'h0000_0380);
    wchk(ADDR_STATE_SUMMARY, 32'h0, 2'b10);
  endtask
  task automatic t_msgs();
    logic [15:0] pf;
    wchk(ADDR_IRQ_MASK, 32'hF, 2'b00);
    rdw(ADDR_IRQ_STATUS);
    for (int k = 0; k < 5; k++)
    begin
      pf = {4'(k), (k == 4) ? 12'h000 : 12'h004};
      send(32'h1234_E001, 4'(k % 3), pf);
      check({31'h0, irq}, 32'h1);
      rchk(ADDR_IRQ_STATUS, 32'h2);
      rchk(slot(k, 1), {16'hA5C3, 12'h0, 4'(k % 3)});
      rchk(slot(k, 4), {16'h1357, pf});
    end
    rchk(slot(0, 0), 32'h1234_E001);
    rchk(slot(0, 2), 32'h5566_7788);
    rchk(slot(0, 3), 32'h1122_3344);
    rchk(slot(0, 5), 32'h89AB_CDEF);
    rchk(slot(0, 6), 32'h0123_4567);
    check(epCount, 0);
    bad(32'hFFFF_0001, 4'h1, 16'h0007);
    bad(32'h0000_0001, 4'h1, 16'h0007);
    bad(32'hFFFE_0001, 4'h3, 16'h0007);
    bad(32'hFFFE_0001, 4'h1, 16'h5000);
    bad(32'hFFFE_0001, 4'h1, 16'h4001);
    for (int s = 0; s < 3; s++)
    begin
      wchk(ADDR_HISTORY_FLAGS, 32'(2 << s), 2'b00);
      send(32'h1234_0001, 4'(s), 16'h0007);
      rchk(ADDR_IRQ_STATUS, 32'h8);
    end
    wchk(ADDR_IRQ_MASK, 32'h0, 2'b00);
    send(32'h0000_0001, 4'h0, 16'h0007);
    check({31'h0, irq}, 32'h0);
    rchk(ADDR_IRQ_STATUS, 32'h4);
    wchk(ADDR_HISTORY_FLAGS, 32'h1, 2'b00);
    send(32'h1234_E001, 4'h2, 16'h0007);
    check(epCount, 1);
    rchk(ADDR_DIAG_STATUS, 32'h0605);
  endtask
  task automatic closeOut();
    $display("comparisons %0d, mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial
  begin
    {reset_n, av, wv, br, arv, rr, mv, lk, so, cf} <= '0;
    {aa, ra, wd} <= '0;
    msg <= '0;
    ts <= 64'h1122_3344_5566_7788;
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    t_regs();
    t_states();
    t_summary();
    t_msgs();
    closeOut();
  end
  initial
  begin
    repeat (50000) @(posedge clock);
    failCount++;
    closeOut();
  end
endmodule
bind fieldbus_master_state_diag fieldbus_diag_assertions chk (.clock, .reset_n, .s_axi_bvalid,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .masterStatus, .requestedState,
  .diagMsg, .diagMsgValid, .diagMsgReady, .emergencyPulse);
`default_nettype wire
